/* rtl/sck_defines.svh */
// How it works
// - Fixed 156.25 MHz reference clock, third pair
// - Lock flag mirrors external clocking PLL
// - Valid only when source valid and locked
// - Four debug clocks reach frequency counters
// - Drive high lights red or green LED
// - Platform may override each LED temporarily
// - Stretcher lights LED at least 100 ms
// - Continuous 10 MHz system clock to user
// - Config done asserts after self-config, stays high
// - Each reset release restarts self-configuration
`ifndef SCK_DEFINES_SVH
`define SCK_DEFINES_SVH
`define SCK_CLK_HZ 10000000
`define SCK_FIXED_REF_KHZ 156250
`define SCK_STRETCH_MS 100
`define SCK_STRETCH_CYC ((`SCK_STRETCH_MS * (`SCK_CLK_HZ / 1000)))
`define SCK_CFG_STEPS 16
`define SCK_NUM_DEBUG 4
`endif

/* rtl/sck_pkg.sv */
package sck_pkg;
	typedef enum logic [1:0] {
		CFG_IDLE,
		CFG_RUN,
		CFG_DONE
	} sck_cfg_state_t;
endpackage : sck_pkg

/* rtl/sck_stretch.sv */
`timescale 1ns/1ps
`include "sck_defines.svh"
module sck_stretch #(
	parameter int STRETCH_CYC = `SCK_STRETCH_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic drive_async,
	input wire logic override_en,
	input wire logic override_val,
	output logic led_out
);
	// ----------------------------------------
	// Input capture
	// ----------------------------------------
	logic s1_q, s2_q, s3_q;
	logic [31:0] cnt_q;
	// Either stage counts, so a single-cycle drive is never filtered away
	wire hit = s2_q | s3_q;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= drive_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	// ----------------------------------------
	// Stretch counter
	// ----------------------------------------
	// Retrigger keeps the LED lit through bursts
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_q <= 32'h0000_0000;
		end else if (hit) begin
			cnt_q <= 32'(STRETCH_CYC);
		end else if (cnt_q != 32'h0000_0000) begin
			cnt_q <= cnt_q - 32'h0000_0001;
		end
	end
	wire lit = cnt_q != 32'h0000_0000;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			led_out <= 1'b0;
		end else begin
			led_out <= override_en ? override_val : lit;
		end
	end
	chk_stretch_hold: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(lit) |-> lit [*8]) else $error("stretch ended early");
	chk_override_wins: assert property (@(posedge clk_sys) disable iff (rst)
		override_en |=> led_out == $past(override_val)) else $error("override lost");
	cov_stretch: cover property (@(posedge clk_sys) disable iff (rst) $fell(lit));
endmodule : sck_stretch

/* rtl/sck_socket.sv */
`timescale 1ns/1ps
`include "sck_defines.svh"
module sck_socket #(
	parameter int STRETCH_CYC = `SCK_STRETCH_CYC,
	parameter int CFG_STEPS = `SCK_CFG_STEPS
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic fixed_ref_clk_in,
	input wire logic ref_a_clk_in,
	input wire logic ref_b_clk_in,
	input wire logic ext_pll_lock_in,
	input wire logic src_valid_in,
	input wire logic [`SCK_NUM_DEBUG-1:0] debug_clock_probes,
	input wire logic activity_led_red,
	input wire logic activity_led_green,
	input wire logic red_override_en,
	input wire logic red_override_val,
	input wire logic green_override_en,
	input wire logic green_override_val,
	input wire logic front_end_config_ready,
	input wire logic exported_user_ref_clock,
	output logic xcvr_ref_clock_fixed,
	output logic xcvr_ref_clock_a,
	output logic xcvr_ref_clock_b,
	output logic socket_sys_clock,
	output logic async_socket_reset,
	output logic ref_pll_locked,
	output logic ref_clocks_valid,
	output logic [`SCK_NUM_DEBUG-1:0] debug_clock_out,
	output logic led_red_pin,
	output logic led_green_pin,
	output logic front_end_config_done,
	output logic front_end_config_prepare
);
	import sck_pkg::*;
	// ----------------------------------------
	// Clock distribution
	// ----------------------------------------
	// Pad clocks pass straight; user must buffer them itself
	assign xcvr_ref_clock_fixed = fixed_ref_clk_in;
	assign xcvr_ref_clock_a = ref_a_clk_in;
	assign xcvr_ref_clock_b = ref_b_clk_in;
	assign socket_sys_clock = clk_sys;
	assign async_socket_reset = rst;
	genvar g;
	generate
		for (g = 0; g < `SCK_NUM_DEBUG; g++) begin : g_dbg
			assign debug_clock_out[g] = debug_clock_probes[g];
		end
	endgenerate
	// ----------------------------------------
	// Clock status
	// ----------------------------------------
	// Left asynchronous on purpose: user samples it
	assign ref_pll_locked = ext_pll_lock_in;
	assign ref_clocks_valid = src_valid_in & ext_pll_lock_in;
	// ----------------------------------------
	// LEDs
	// ----------------------------------------
	sck_stretch #(.STRETCH_CYC(STRETCH_CYC)) u_red (
		.clk_sys(clk_sys),
		.rst(rst),
		.drive_async(activity_led_red),
		.override_en(red_override_en),
		.override_val(red_override_val),
		.led_out(led_red_pin)
	);
	sck_stretch #(.STRETCH_CYC(STRETCH_CYC)) u_green (
		.clk_sys(clk_sys),
		.rst(rst),
		.drive_async(activity_led_green),
		.override_en(green_override_en),
		.override_val(green_override_val),
		.led_out(led_green_pin)
	);
	// ----------------------------------------
	// Self-configuration
	// ----------------------------------------
	sck_cfg_state_t st_q;
	logic [15:0] step_q;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_q <= CFG_IDLE;
			step_q <= 16'h0000;
		end else begin
			unique case (st_q)
				CFG_IDLE: begin
					st_q <= CFG_RUN;
					step_q <= 16'h0000;
				end
				CFG_RUN: begin
					if (step_q == 16'(CFG_STEPS - 1)) begin
						st_q <= CFG_DONE;
					end
					step_q <= step_q + 16'h0001;
				end
				CFG_DONE: begin
					st_q <= CFG_DONE;
				end
			endcase
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			front_end_config_done <= 1'b0;
		end else begin
			front_end_config_done <= st_q == CFG_DONE;
		end
	end
	// Reserved: held low, ready input ignored
	assign front_end_config_prepare = 1'b0;
	chk_valid_needs_lock: assert property (@(posedge clk_sys) disable iff (rst)
		ref_clocks_valid |-> ref_pll_locked && src_valid_in) else $error("valid without lock");
	chk_done_sticky: assert property (@(posedge clk_sys) disable iff (rst)
		front_end_config_done |=> front_end_config_done) else $error("done dropped");
	chk_done_after_cfg: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(st_q == CFG_RUN) |-> !front_end_config_done [*3]) else $error("done too early");
	chk_lock_mirror: assert property (@(posedge clk_sys) disable iff (rst)
		ref_pll_locked == ext_pll_lock_in) else $error("lock not mirrored");
	cov_done: cover property (@(posedge clk_sys) disable iff (rst) $rose(front_end_config_done));
	cov_valid: cover property (@(posedge clk_sys) disable iff (rst) $rose(ref_clocks_valid));
endmodule : sck_socket

/* sim/sck_user_model.sv */
`timescale 1ns/1ps
`include "sck_defines.svh"
// ----
// User block stand-in
// ----
module sck_user_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic cfg_done,
	input wire logic clk_valid,
	input wire logic led_req,
	input wire logic front_end_config_prepare,
	output logic activity_led_red,
	output logic front_end_config_ready,
	output logic exported_user_ref_clock,
	output logic [`SCK_NUM_DEBUG-1:0] debug_clock_probes
);
	logic [`SCK_NUM_DEBUG-1:0] cnt_q;
	logic valid_q;
	// Reference pads left unused here, so no pad buffer is needed
	assign front_end_config_ready = front_end_config_prepare;
	assign exported_user_ref_clock = 1'b0;
	// Synchronous drive, one whole cycle
	assign activity_led_red = led_req;
	// Toggling probes so a stuck path shows
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
			valid_q <= 1'b0;
		end else begin
			valid_q <= clk_valid;
			if (clk_valid && !valid_q) begin
				cnt_q <= '0;
			end else if (cfg_done && clk_valid) begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end
	assign debug_clock_probes = cnt_q;
endmodule : sck_user_model

/* sim/test_ip_socket_clock_status_led_port.sv */
`timescale 1ns/1ps
`include "sck_defines.svh"
// ----
// Socket bench
// ----
module test_ip_socket_clock_status_led_port;
	localparam int SC = 20;
	localparam int CS = 4;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic fx = 0, ra = 0, rb = 0, lk = 0, sv = 0, req = 0, grn = 0;
	logic roe = 0, rov = 0, goe = 0, gov = 0;
	logic rdy, exc, xf, xa, xb, sck, ars, plk, vld, lr, lg, done, prep, ulr;
	logic [3:0] dbg, dbo;
	int n_errors = 0;
	int comparisons = 0;
	sck_user_model um (.clk_sys(clk_sys), .rst(rst), .cfg_done(done), .clk_valid(vld),
		.led_req(req), .front_end_config_prepare(prep),
		.activity_led_red(ulr), .front_end_config_ready(rdy), .exported_user_ref_clock(exc),
		.debug_clock_probes(dbg));
	sck_socket #(.STRETCH_CYC(SC), .CFG_STEPS(CS)) dut (.clk_sys(clk_sys), .rst(rst),
		.fixed_ref_clk_in(fx), .ref_a_clk_in(ra), .ref_b_clk_in(rb), .ext_pll_lock_in(lk),
		.src_valid_in(sv), .debug_clock_probes(dbg), .activity_led_red(ulr),
		.activity_led_green(grn), .red_override_en(roe), .red_override_val(rov),
		.green_override_en(goe), .green_override_val(gov), .front_end_config_ready(rdy),
		.exported_user_ref_clock(exc), .xcvr_ref_clock_fixed(xf), .xcvr_ref_clock_a(xa),
		.xcvr_ref_clock_b(xb), .socket_sys_clock(sck), .async_socket_reset(ars),
		.ref_pll_locked(plk), .ref_clocks_valid(vld), .debug_clock_out(dbo),
		.led_red_pin(lr), .led_green_pin(lg), .front_end_config_done(done),
		.front_end_config_prepare(prep));
	initial forever #50 clk_sys = ~clk_sys;
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : step
	// Callers wait a quarter cycle first, away from both clock edges
	task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task automatic t_config;
		step(1);
		rst <= 1'b1;
		step(6);
		#25;
		cmp(done, 0);
		cmp(ars, 1);
		step(1);
		rst <= 1'b0;
		step(CS);
		#25;
		cmp(done, 0);
		step(3);
		#25;
		cmp(done, 1);
		step(20);
		#25;
		cmp(done, 1);
	endtask : t_config
	task automatic t_status;
		for (int i = 0; i < 4; i++) begin
			step(1);
			{lk, sv} <= i[1:0];
			#25;
			cmp(plk, i[1]);
			cmp(vld, i[1] & i[0]);
		end
	endtask : t_status
	task automatic t_pass;
		step(1);
		fx <= 1'b1;
		rb <= 1'b1;
		#25;
		cmp({xf, xa, xb, sck}, 4'b1011);
		cmp(dbo, dbg);
	endtask : t_pass
	task automatic t_led;
		step(1);
		req <= 1'b1;
		grn <= 1'b1;
		step(1);
		req <= 1'b0;
		grn <= 1'b0;
		#25;
		cmp({lr, lg}, 0);
		step(3);
		#25;
		cmp({lr, lg}, 3);
		step(SC - 2);
		#25;
		cmp({lr, lg}, 3);
		step(10);
		#25;
		cmp({lr, lg}, 0);
	endtask : t_led
	task automatic t_override;
		step(1);
		{roe, rov, goe, gov} <= 4'b1110;
		grn <= 1'b1;
		step(1);
		grn <= 1'b0;
		step(6);
		#25;
		cmp({lr, lg}, 2);
		step(1);
		{roe, goe} <= 2'b00;
		step(2);
		#25;
		cmp({lr, lg}, 1);
		step(SC + 8);
		#25;
		cmp({lr, lg}, 0);
	endtask : t_override
	task automatic summarize;
		if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : summarize
	initial begin
		t_config();
		t_status();
		t_pass();
		t_led();
		t_override();
		t_config();
		summarize();
	end
	initial begin
		step(2000);
		n_errors++;
		summarize();
	end
endmodule : test_ip_socket_clock_status_led_port
